// ---- dual_port_sync_ram.sv ----
// Synchronous dual-port memory with per-port write modes and options.
// Assumes both ports and the control bus run on clk; users avoid
// same-address write collisions between ports.
//
// Behaviour
// - Read samples address at rising edge, word appears on output after it.
// - Write strobe at a rising edge stores input word at port address.
// - Each port selects one of three write modes independently.
// - Write-first: stored word also appears on output at same edge.
// - Read-first: old word at write address appears while new stored.
// - No-change: write leaves output holding last read word.
// - Write mode is a fixed build-time setting.
// - Without a chosen mode a port behaves write-first.
// - Same-location access by both ports causes no damage or lock-up.
// - Single-edge write timing holds without input or extra output registers.
// - Data width is a parameter from 1 to 256 bits.
// - Depth is a parameter from 512 to 1M words in 512 steps.
// - Enabled port without write strobe reads, whatever its write mode.
// - Output preset loads output register with build value, memory untouched.
// - Input register and extra output stage each add one cycle latency.
// - Output-valid follows new-request flag after exactly the read latency.
`timescale 1ns/10ps
module dual_port_sync_ram
  import dpram_pkg::*;
#(
  parameter int          DATA_WIDTH    = 16,
  parameter int          DEPTH         = 512,
  parameter write_mode_t WRITE_MODE_A  = WRITE_FIRST,
  parameter write_mode_t WRITE_MODE_B  = WRITE_FIRST,
  parameter bit          HAS_ENABLE    = 1'b0,
  parameter bit          HAS_HANDSHAKE = 1'b0,
  parameter bit          REG_INPUTS    = 1'b0,
  parameter int          OUT_STAGES    = 0,
  parameter bit          HAS_PRESET    = 1'b0,
  parameter logic [DATA_WIDTH-1:0] PRESET_VALUE_A = '0,
  parameter logic [DATA_WIDTH-1:0] PRESET_VALUE_B = '0,
  parameter int          AW            = $clog2(DEPTH)
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [AW-1:0]         addrA,
  input  wire logic [DATA_WIDTH-1:0] dinA,
  input  wire logic                  writeA,
  input  wire logic                  portAActive,
  input  wire logic                  outputPresetA,
  input  wire logic                  newRequestFlagA,
  output logic      [DATA_WIDTH-1:0] doutA,
  output logic                       acceptOkA,
  output logic                       outReadyA,
  input  wire logic [AW-1:0]         addrB,
  input  wire logic [DATA_WIDTH-1:0] dinB,
  input  wire logic                  writeB,
  input  wire logic                  portBActive,
  input  wire logic                  outputPresetB,
  input  wire logic                  newRequestFlagB,
  output logic      [DATA_WIDTH-1:0] doutB,
  output logic                       acceptOkB,
  output logic                       outReadyB,
  input  wire logic [3:0]            address,
  input  wire logic [3:0]            byteenable,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest
);

  localparam int LAT = BASE_LAT + int'(REG_INPUTS) + OUT_STAGES;
  localparam write_mode_t MODES [2] = '{WRITE_MODE_A, WRITE_MODE_B};

  typedef struct packed {
    logic [1:0][DATA_WIDTH-1:0] core;
    logic [1:0][DATA_WIDTH-1:0] outer;
    logic [1:0][MAX_LAT-1:0]    ndPipe;
  } state_t;

  state_t stateQ;
  state_t stateD;

  logic [DATA_WIDTH-1:0] mem [DEPTH];

  port_ctl_t [1:0]                 ctlRaw;
  port_ctl_t [1:0]                 ctlE;
  logic      [1:0][AW-1:0]         addrRaw;
  logic      [1:0][AW-1:0]         addrE;
  logic      [1:0][DATA_WIDTH-1:0] dinRaw;
  logic      [1:0][DATA_WIDTH-1:0] dinE;
  logic      [1:0][DATA_WIDTH-1:0] memRd;
  logic      [1:0][DATA_WIDTH-1:0] presetVal;
  logic                            conflictEvent;
  logic                            detectEnable;
  bus_req_t                        busReq;
  logic      [CONFIG_WIDTH-1:0]    configWord;

  // Output register value for one port on an active edge
  function automatic logic [DATA_WIDTH-1:0] next_out(
    input write_mode_t           mode,
    input logic                  we,
    input logic [DATA_WIDTH-1:0] din,
    input logic [DATA_WIDTH-1:0] oldWord,
    input logic [DATA_WIDTH-1:0] held
  );
    logic [DATA_WIDTH-1:0] res;
    res = oldWord;
    if (we) begin
      unique case (mode)
        WRITE_FIRST: res = din;
        READ_FIRST:  res = oldWord;
        NO_CHANGE:   res = held;
        default:     res = din;
      endcase
    end
    return res;
  endfunction

  // Unbuilt preset and handshake are forced inactive; an unbuilt enable forces the port active
  assign ctlRaw[0] = '{active: HAS_ENABLE ? portAActive : 1'b1, we: writeA,
                       preset: HAS_PRESET & outputPresetA,
                       nd: HAS_HANDSHAKE & newRequestFlagA};
  assign ctlRaw[1] = '{active: HAS_ENABLE ? portBActive : 1'b1, we: writeB,
                       preset: HAS_PRESET & outputPresetB,
                       nd: HAS_HANDSHAKE & newRequestFlagB};
  assign addrRaw   = {addrB, addrA};
  assign dinRaw    = {dinB, dinA};
  assign presetVal = {PRESET_VALUE_B, PRESET_VALUE_A};

  for (genvar p = 0; p < 2; p++) begin : g_in
    port_input_stage #(
      .AW     (AW),
      .DW     (DATA_WIDTH),
      .REG_IN (REG_INPUTS)
    ) u_in (
      .clk     (clk),
      .rst     (rst),
      .ctlIn   (ctlRaw[p]),
      .addrIn  (addrRaw[p]),
      .dinIn   (dinRaw[p]),
      .ctlOut  (ctlE[p]),
      .addrOut (addrE[p]),
      .dinOut  (dinE[p])
    );
    assign memRd[p] = mem[addrE[p]];
  end

  // Both ports may write; a same-address collision just leaves port B's word
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (ctlE[p].active && ctlE[p].we) begin
        mem[addrE[p]] <= dinE[p];
      end
    end
  end

  always_comb begin
    stateD = stateQ;
    for (int p = 0; p < 2; p++) begin
      if (ctlE[p].active) begin
        if (ctlE[p].preset) begin
          stateD.core[p] = presetVal[p];
        end else begin
          stateD.core[p] = next_out(MODES[p], ctlE[p].we, dinE[p], memRd[p],
                                    stateQ.core[p]);
        end
        if (ctlE[p].preset) begin
          stateD.outer[p] = presetVal[p];
        end else begin
          stateD.outer[p] = stateQ.core[p];
        end
      end
      if (ctlRaw[p].active) begin
        stateD.ndPipe[p] = {stateQ.ndPipe[p][MAX_LAT-2:0], ctlRaw[p].nd};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ       <= '0;
      stateQ.core  <= presetVal;
      stateQ.outer <= presetVal;
    end else begin
      stateQ <= stateD;
    end
  end

  assign doutA     = (OUT_STAGES > 0) ? stateQ.outer[0] : stateQ.core[0];
  assign doutB     = (OUT_STAGES > 0) ? stateQ.outer[1] : stateQ.core[1];
  assign outReadyA = stateQ.ndPipe[0][LAT-1];
  assign outReadyB = stateQ.ndPipe[1][LAT-1];
  assign acceptOkA = HAS_HANDSHAKE & ctlRaw[0].active;
  assign acceptOkB = HAS_HANDSHAKE & ctlRaw[1].active;

  // Same-cycle overlap with a write is only flagged while detection is enabled, never blocked
  assign conflictEvent = detectEnable & ctlE[0].active & ctlE[1].active
                       & (addrE[0] == addrE[1]) & (ctlE[0].we | ctlE[1].we);

  assign busReq = '{read: read, write: write, address: address,
                    byteenable: byteenable, writedata: writedata};
  assign configWord = {2'(MAX_LAT'(LAT)), 2'(MAX_LAT'(LAT)), WRITE_MODE_B, WRITE_MODE_A};

  csr_slave u_csr (
    .clk           (clk),
    .rst           (rst),
    .req           (busReq),
    .conflictEvent (conflictEvent),
    .configWord    (configWord),
    .readdata      (readdata),
    .waitrequest   (waitrequest),
    .detectEnable  (detectEnable),
    .conflictFlag  ()
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_param_range: assert property (DATA_WIDTH >= MIN_WIDTH && DATA_WIDTH <= MAX_WIDTH
    && DEPTH >= MIN_DEPTH && DEPTH <= MAX_DEPTH && DEPTH % DEPTH_STEP == 0)
    else $error("width or depth out of range");

  for (genvar p = 0; p < 2; p++) begin : g_chk
    a_read_data: assert property (ctlE[p].active && !ctlE[p].we && !ctlE[p].preset
      |=> stateQ.core[p] === $past(memRd[p]))
      else $error("read data mismatch");

    a_write_store: assert property (ctlE[p].active && ctlE[p].we
      && !(ctlE[1-p].active && ctlE[1-p].we && addrE[1-p] == addrE[p])
      |=> mem[$past(addrE[p])] === $past(dinE[p]))
      else $error("write not stored");

    a_write_first: assert property (MODES[p] == WRITE_FIRST && ctlE[p].active
      && ctlE[p].we && !ctlE[p].preset |=> stateQ.core[p] == $past(dinE[p]))
      else $error("write-first output wrong");

    a_read_first: assert property (MODES[p] == READ_FIRST && ctlE[p].active
      && ctlE[p].we && !ctlE[p].preset |=> stateQ.core[p] === $past(memRd[p]))
      else $error("read-first output wrong");

    a_no_change: assert property (MODES[p] == NO_CHANGE && ctlE[p].active
      && ctlE[p].we && !ctlE[p].preset |=> $stable(stateQ.core[p]))
      else $error("no-change output moved");

    a_enable_freeze: assert property (!ctlE[p].active
      |=> $stable(stateQ.core[p]) && $stable(stateQ.outer[p]))
      else $error("disabled port changed output");

    a_preset_load: assert property (ctlE[p].active && ctlE[p].preset
      |=> stateQ.core[p] == presetVal[p])
      else $error("preset not loaded");

    a_extra_stage: assert property (OUT_STAGES > 0 && ctlE[p].active && !ctlE[p].preset
      |=> stateQ.outer[p] === $past(stateQ.core[p]))
      else $error("extra output stage wrong");

    // Each active edge moves the request flag one stage nearer the valid output
    a_ready_lag: assert property (HAS_HANDSHAKE == 1 && ctlRaw[p].active
      |=> stateQ.ndPipe[p] === {$past(stateQ.ndPipe[p][MAX_LAT-2:0]), $past(ctlRaw[p].nd)})
      else $error("ready does not lag request by latency");
  end

  c_wf_write: cover property (ctlE[0].active && ctlE[0].we ##1 ctlE[0].active && !ctlE[0].we);
  c_both_read_same: cover property (ctlE[0].active && ctlE[1].active
    && addrE[0] == addrE[1] && !ctlE[0].we && !ctlE[1].we);
  c_conflict: cover property (conflictEvent);
  c_ready: cover property (outReadyA ##1 outReadyB);

endmodule // dual_port_sync_ram

// ---- dpram_pkg.sv ----
// Shared types and constants for the dual-port synchronous memory.
// Assumes a single clock domain and an Avalon-MM control slave.
package dpram_pkg;

  typedef enum logic [1:0] {
    WRITE_FIRST = 2'b00,
    READ_FIRST  = 2'b01,
    NO_CHANGE   = 2'b10
  } write_mode_t;

  typedef struct packed {
    logic active;
    logic we;
    logic preset;
    logic nd;
  } port_ctl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } bus_req_t;

  localparam int unsigned MIN_WIDTH   = 1;
  localparam int unsigned MAX_WIDTH   = 256;
  localparam int unsigned MIN_DEPTH   = 512;
  localparam int unsigned DEPTH_STEP  = 512;
  localparam int unsigned MAX_DEPTH   = 1048576;
  localparam int unsigned BASE_LAT    = 1;
  localparam int unsigned MAX_LAT     = 3;

  localparam logic [3:0] CTRL_OFS     = 4'h0;
  localparam logic [3:0] STATUS_OFS   = 4'h4;
  localparam logic [3:0] CONFIG_OFS   = 4'h8;

  localparam int CTRL_DETECT_BIT      = 0;
  localparam int STATUS_CONFLICT_BIT  = 0;
  localparam int CONFIG_MODE_A_LSB    = 0;
  localparam int CONFIG_MODE_B_LSB    = 2;
  localparam int CONFIG_LAT_A_LSB     = 4;
  localparam int CONFIG_LAT_B_LSB     = 6;
  localparam int CONFIG_WIDTH         = 8;

  localparam logic        CTRL_DETECT_RST = 1'b1;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

endpackage

// ---- port_input_stage.sv ----
// Optional input register for one memory port (control, address, data).
// Assumes all inputs come from logic on clk.
`timescale 1ns/10ps
module port_input_stage
  import dpram_pkg::*;
#(
  parameter int AW     = 9,
  parameter int DW     = 16,
  parameter bit REG_IN = 1'b0
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire port_ctl_t     ctlIn,
  input  wire logic [AW-1:0] addrIn,
  input  wire logic [DW-1:0] dinIn,
  output port_ctl_t          ctlOut,
  output logic      [AW-1:0] addrOut,
  output logic      [DW-1:0] dinOut
);

  typedef struct packed {
    port_ctl_t     ctl;
    logic [AW-1:0] addr;
    logic [DW-1:0] din;
  } state_t;

  state_t stateQ;
  state_t stateD;

  always_comb begin
    stateD      = stateQ;
    stateD.ctl  = ctlIn;
    stateD.addr = addrIn;
    stateD.din  = dinIn;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  // One extra cycle of latency when registered
  assign ctlOut  = REG_IN ? stateQ.ctl  : ctlIn;
  assign addrOut = REG_IN ? stateQ.addr : addrIn;
  assign dinOut  = REG_IN ? stateQ.din  : dinIn;

endmodule // port_input_stage

// ---- csr_slave.sv ----
// Avalon-MM control/status slave for the dual-port memory.
// Assumes one clock; every access answers one cycle after it is raised.
`timescale 1ns/10ps
module csr_slave
  import dpram_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire bus_req_t                req,
  input  wire logic                    conflictEvent,
  input  wire logic [CONFIG_WIDTH-1:0] configWord,
  output logic      [31:0]             readdata,
  output logic                         waitrequest,
  output logic                         detectEnable,
  output logic                         conflictFlag
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        detect;
    logic        sticky;
  } state_t;

  state_t stateQ;
  state_t stateD;
  logic   busy;
  logic   clrHit;

  assign busy = req.read | req.write;

  always_comb begin
    stateD     = stateQ;
    stateD.ack = busy & ~stateQ.ack;
    clrHit     = 1'b0;
    if (busy && !stateQ.ack) begin
      unique case (req.address)
        CTRL_OFS:   stateD.rdata = {31'h0000_0000, stateQ.detect};
        STATUS_OFS: stateD.rdata = {31'h0000_0000, stateQ.sticky};
        CONFIG_OFS: stateD.rdata = {24'h00_0000, configWord};
        default:    stateD.rdata = READ_ZERO;
      endcase
    end
    if (req.write && stateQ.ack && req.byteenable[0]) begin
      if (req.address == CTRL_OFS) begin
        stateD.detect = req.writedata[CTRL_DETECT_BIT];
      end
      if (req.address == STATUS_OFS) begin
        clrHit = req.writedata[STATUS_CONFLICT_BIT];
      end
    end
    // A new conflict beats a simultaneous clear
    stateD.sticky = conflictEvent | (stateQ.sticky & ~clrHit);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ        <= '0;
      stateQ.detect <= CTRL_DETECT_RST;
    end else begin
      stateQ <= stateD;
    end
  end

  assign waitrequest  = busy & ~stateQ.ack;
  assign readdata     = stateQ.rdata;
  assign detectEnable = stateQ.detect;
  assign conflictFlag = stateQ.sticky;

  a_wait_one_cycle: assert property (@(posedge clk) disable iff (rst)
    (busy && waitrequest) |=> !waitrequest)
    else $error("waitrequest held longer than one cycle");

  a_sticky_set_wins: assert property (@(posedge clk) disable iff (rst)
    conflictEvent |=> stateQ.sticky)
    else $error("conflict event lost");

endmodule // csr_slave

// ---- port_user_model.sv ----
// Behavioural user logic in front of one memory port.
// Assumes the bench raises go with the request fields just after a clock edge.
`timescale 1ns/10ps
module port_user_model #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          go,
  input  wire logic          wr,
  input  wire logic [AW-1:0] adr,
  input  wire logic [DW-1:0] dat,
  input  wire logic          peerGo,
  input  wire logic          peerWr,
  input  wire logic [AW-1:0] peerAdr,
  input  wire logic          clashOk,
  output logic               active,
  output logic               we,
  output logic      [AW-1:0] addr,
  output logic      [DW-1:0] din
);
  logic [AW-1:0] lastAdr_q;
  logic [DW-1:0] lastDat_q;
  logic          block;

  // Hold back an access to the place the peer writes now, unless told to clash
  assign block  = peerGo && peerWr && (peerAdr == adr) && !clashOk;
  assign active = go && !block;
  assign we     = active && wr;
  // Idle lines show a pattern that changes every cycle
  assign addr   = go ? adr : lastAdr_q;
  assign din    = go ? dat : lastDat_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      lastAdr_q <= '0;
      lastDat_q <= '0;
    end else if (go) begin
      lastAdr_q <= ~adr;
      lastDat_q <= ~dat;
    end else begin
      lastAdr_q <= ~lastAdr_q;
      lastDat_q <= ~lastDat_q;
    end
  end
endmodule // port_user_model

// ---- tb_dual_port_sync_ram.sv ----
// Bench for the dual-port memory: a plain build and a build with all options except the input register.
// Assumes one clock for ports and control bus; ports 0,1 plain, 2,3 optioned.
`timescale 1ns/10ps
module tb_dual_port_sync_ram
  import dpram_pkg::*;
;
  localparam logic [15:0] PRE_A = 16'hA5A5;
  localparam logic [15:0] PRE_B = 16'h5A5A;
  logic        clk, rst, clashOk, read, write;
  logic        go [4], wr [4], preset [4], mActive [4], mWe [4], acceptOk [4], outReady [4];
  logic [8:0]  adr [4], mAddr [4];
  logic [15:0] dat [4], mDin [4], dout [4];
  logic [3:0]  address;
  logic [31:0] writedata, r0, r1;
  logic [31:0] readdata [2];
  logic        waitrequest [2];
  int          bad_count = 0;
  int          num_checks = 0;
  int          cycles = 0;

  for (genvar p = 0; p < 4; p++) begin : user_g
    port_user_model #(.AW(9), .DW(16)) port_user_model_i (
      .clk(clk), .rst(rst), .go(go[p]), .wr(wr[p]), .adr(adr[p]), .dat(dat[p]),
      .peerGo(go[p^1]), .peerWr(wr[p^1]), .peerAdr(adr[p^1]), .clashOk(clashOk),
      .active(mActive[p]), .we(mWe[p]), .addr(mAddr[p]), .din(mDin[p]));
  end

  for (genvar g = 0; g < 2; g++) begin : ram_g
    dual_port_sync_ram #(
      .WRITE_MODE_A(g ? READ_FIRST : WRITE_FIRST), .WRITE_MODE_B(g ? NO_CHANGE : WRITE_FIRST),
      .HAS_ENABLE(g == 1), .HAS_HANDSHAKE(g == 1), .HAS_PRESET(g == 1), .OUT_STAGES(g),
      .PRESET_VALUE_A(g ? PRE_A : 16'h0000), .PRESET_VALUE_B(g ? PRE_B : 16'h0000)
    ) dual_port_sync_ram_i (
      .clk(clk), .rst(rst),
      .addrA(mAddr[2*g]), .dinA(mDin[2*g]), .writeA(mWe[2*g]), .portAActive(mActive[2*g]),
      .outputPresetA(preset[2*g]), .newRequestFlagA(go[2*g]), .doutA(dout[2*g]),
      .acceptOkA(acceptOk[2*g]), .outReadyA(outReady[2*g]),
      .addrB(mAddr[2*g+1]), .dinB(mDin[2*g+1]), .writeB(mWe[2*g+1]),
      .portBActive(mActive[2*g+1]), .outputPresetB(preset[2*g+1]),
      .newRequestFlagB(go[2*g+1]), .doutB(dout[2*g+1]),
      .acceptOkB(acceptOk[2*g+1]), .outReadyB(outReady[2*g+1]),
      .address(address), .byteenable(4'hF), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata[g]), .waitrequest(waitrequest[g]));
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic put(int p, logic w, logic [8:0] a, logic [15:0] d);
    go[p] <= 1'b1;
    wr[p] <= w;
    adr[p] <= a;
    dat[p] <= d;
  endtask

  task automatic idle(int p);
    go[p] <= 1'b0;
    wr[p] <= 1'b0;
  endtask

  // One Avalon access on the shared bus; both builds answer together
  task automatic bus(logic w, logic [3:0] a, logic [31:0] wd);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= wd;
    do @(posedge clk); while (waitrequest[0] !== 1'b0);
    r0 = readdata[0];
    r1 = readdata[1];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic t_write_first();
    @(posedge clk);
    put(0, 1'b1, 9'h005, 16'h1234);
    put(1, 1'b1, 9'h007, 16'hBEEF);
    preset[0] <= 1'b1;
    @(posedge clk);
    put(0, 1'b0, 9'h007, 16'h0000);
    put(1, 1'b0, 9'h005, 16'h0000);
    @(negedge clk);
    check("doutA wf", 32'(dout[0]), 32'h1234);
    check("doutB wf", 32'(dout[1]), 32'hBEEF);
    @(posedge clk);
    idle(0);
    idle(1);
    preset[0] <= 1'b0;
    @(negedge clk);
    check("doutA rd", 32'(dout[0]), 32'hBEEF);
    check("doutB rd", 32'(dout[1]), 32'h1234);
    check("rdyA off", 32'(outReady[0]), 32'h0);
    check("rfdA off", 32'(acceptOk[0]), 32'h0);
  endtask

  task automatic t_modes();
    @(posedge clk);
    put(2, 1'b1, 9'h003, 16'h1111);
    put(3, 1'b1, 9'h009, 16'h3333);
    @(posedge clk);
    put(2, 1'b1, 9'h003, 16'h2222);
    put(3, 1'b0, 9'h009, 16'h0000);
    @(negedge clk);
    check("rdyB early", 32'(outReady[3]), 32'h0);
    check("rfdB", 32'(acceptOk[3]), 32'h1);
    @(posedge clk);
    put(2, 1'b0, 9'h003, 16'h0000);
    put(3, 1'b1, 9'h009, 16'h4444);
    @(negedge clk);
    check("rdyB", 32'(outReady[3]), 32'h1);
    check("doutB lat", 32'(dout[3]), 32'(PRE_B));
    @(posedge clk);
    idle(2);
    put(3, 1'b0, 9'h009, 16'h0000);
    @(negedge clk);
    check("doutA rf", 32'(dout[2]), 32'h1111);
    check("doutB rd", 32'(dout[3]), 32'h3333);
    @(posedge clk);
    @(negedge clk);
    check("doutA off", 32'(dout[2]), 32'h1111);
    check("doutB nc", 32'(dout[3]), 32'h3333);
    @(posedge clk);
    idle(3);
    @(negedge clk);
    check("doutB new", 32'(dout[3]), 32'h4444);
  endtask

  task automatic t_preset();
    @(posedge clk);
    put(2, 1'b1, 9'h004, 16'h4444);
    put(3, 1'b1, 9'h008, 16'h5555);
    preset[2] <= 1'b1;
    @(posedge clk);
    put(2, 1'b0, 9'h004, 16'h0000);
    put(3, 1'b0, 9'h008, 16'h0000);
    preset[2] <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("doutA preset", 32'(dout[2]), 32'(PRE_A));
    @(posedge clk);
    idle(2);
    idle(3);
    @(negedge clk);
    check("memA kept", 32'(dout[2]), 32'h4444);
    check("memB kept", 32'(dout[3]), 32'h5555);
  endtask

  task automatic t_regs();
    bus(1'b0, CTRL_OFS, 32'h0);
    check("ctrl", r0, 32'h1);
    bus(1'b0, CONFIG_OFS, 32'h0);
    check("config plain", r0, 32'h50);
    check("config opts", r1, 32'hA9);
    bus(1'b1, CONFIG_OFS, 32'hFF);
    bus(1'b0, CONFIG_OFS, 32'h0);
    check("config ro", r0, 32'h50);
    bus(1'b0, 4'hC, 32'h0);
    check("unmapped", r0, 32'h0);
  endtask

  task automatic t_clash();
    bus(1'b1, STATUS_OFS, 32'h1);
    bus(1'b0, STATUS_OFS, 32'h0);
    check("status clear", r0, 32'h0);
    @(posedge clk);
    clashOk <= 1'b1;
    put(0, 1'b1, 9'h002, 16'hABCD);
    put(1, 1'b0, 9'h002, 16'h0000);
    @(posedge clk);
    clashOk <= 1'b0;
    idle(0);
    @(posedge clk);
    idle(1);
    @(negedge clk);
    check("clash word", 32'(dout[1]), 32'hABCD);
    bus(1'b0, STATUS_OFS, 32'h0);
    check("status clash", r0, 32'h1);
    bus(1'b1, STATUS_OFS, 32'h1);
    bus(1'b0, STATUS_OFS, 32'h0);
    check("status w1c", r0, 32'h0);
  endtask

  initial begin
    rst = 1'b1;
    clashOk = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    for (int p = 0; p < 4; p++) begin
      go[p] = 1'b0;
      wr[p] = 1'b0;
      preset[p] = 1'b0;
      adr[p] = 9'h000;
      dat[p] = 16'h0000;
    end
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("reset plain", 32'(dout[0]), 32'h0);
    check("reset presetA", 32'(dout[2]), 32'(PRE_A));
    check("reset rdy", 32'(outReady[2]), 32'h0);
    t_write_first();
    t_modes();
    t_preset();
    t_regs();
    t_clash();
    print_verdict();
  end
endmodule // tb_dual_port_sync_ram
